// File: vpm_pkg.sv
// Purpose: shared constants and types for the virtual partition map block
// Assumes: one core clock, system-register requests arrive from core logic on that clock
// Notes: map registers 1 and 2 only; map registers 0 and 3 onward live elsewhere
// Notes on behaviour
// [R1] map registers are written by move-to and read by move-from register instructions
// [R2] decode op0 11, op1 100, CRn 1010, CRm 0110 for both registers
// [R3] op2 001 selects map register 1, op2 010 selects map register 2
// [R4] map register 2 holds physical ids for virtual ids 8 to 11
// [R5] register 2 entries: id 11 [63:48], 10 [47:32], 9 [31:16], 8 [15:0]
// [R6] each map register is 64 bits wide
// [R7] highest map register index reports last implemented register, at most 7
// [R8] highest index zero means only map register 0 exists
// [R9] register 2 exists only with hypervisor control present and highest index above 1
// [R10] el1 and el0 identifiers translate only when their map enable bit is set
// [R11] entry n is valid only while map entry valid bit n is 1
// [R12] map contents are ignored when el2 is not enabled in current security state
// [R13] map fields may reset to unknown values; software programs them first
// [R14] el0 denied, el3 read-write always, el2 only with non-secure or secure el2
// [R15] nested virt with memory and no general trap redirects el1 to base plus offset
// [R16] general trap with el2 enabled makes el1 access not applicable
// [R17] trap lower levels sends every el2 access to el3
// [R18] trap lower levels with nested virt only sends el1 access to el3
// [R19] el1 traps to el2 under host extension and nested virt without memory
// [R20] map register 1 holds virtual ids 4 to 7, lowest at [15:0]
// [R21] register 1 exists only with hypervisor control present and highest index above 0
// [R22] valid enabled entries replace the virtual id on outgoing requests
package vpm_pkg;
	localparam int VPM_DATA_W = 64;
	localparam int VPM_ID_W = 16;
	localparam int VPM_ENTRY_W = 16;
	localparam int VPM_ENTRIES_PER_REG = 4;
	localparam int VPM_REG_COUNT = 2;
	localparam int VPM_FIRST_VID = 4;
	localparam int VPM_VALID_W = 32;
	localparam int VPM_BASE_W = 52;
	localparam int VPM_BASE_SHIFT = 12;
	localparam logic [1:0] VPM_OP0 = 2'h3;
	localparam logic [2:0] VPM_OP1 = 3'h4;
	localparam logic [3:0] VPM_CRN = 4'hA;
	localparam logic [3:0] VPM_CRM = 4'h6;
	localparam logic [2:0] VPM_OP2_MAP1 = 3'h1;
	localparam logic [2:0] VPM_OP2_MAP2 = 3'h2;
	localparam logic [2:0] VPM_MIN_INDEX_MAP1 = 3'h0;
	localparam logic [2:0] VPM_MIN_INDEX_MAP2 = 3'h1;
	localparam logic [11:0] VPM_MEM_OFS_MAP1 = 12'h948;
	localparam logic [11:0] VPM_MEM_OFS_MAP2 = 12'h950;
	localparam logic [VPM_DATA_W-1:0] VPM_RDATA_RESET = 64'h0000_0000_0000_0000;
	localparam logic [VPM_ID_W-1:0] VPM_ID_RESET = 16'h0000;

	typedef enum logic [1:0] {
		VPM_EL0 = 2'h0,
		VPM_EL1 = 2'h1,
		VPM_EL2 = 2'h2,
		VPM_EL3 = 2'h3
	} vpm_el_t;

	typedef enum logic [2:0] {
		VPM_RESP_OK = 3'h0,
		VPM_RESP_UNDEF = 3'h1,
		VPM_RESP_TRAP_EL2 = 3'h3,
		VPM_RESP_TRAP_EL3 = 3'h2,
		VPM_RESP_MEM = 3'h6
	} vpm_resp_t;
endpackage : vpm_pkg

// File: vpm_store_if.sv
// Purpose: carrier between the access logic and the map storage
// Assumes: all signals on the core clock
// Notes: lookup ports a and b serve the el1 and el0 identifiers
`timescale 1ns/1ps
interface vpm_store_if;
	import vpm_pkg::*;
	logic wr_en;
	logic [0:0] sel;
	logic [VPM_DATA_W-1:0] wdata;
	logic [VPM_DATA_W-1:0] rdata;
	logic [VPM_ID_W-1:0] vid_a;
	logic [VPM_ID_W-1:0] vid_b;
	logic [VPM_ID_W-1:0] pid_a;
	logic [VPM_ID_W-1:0] pid_b;
	logic hit_a;
	logic hit_b;
	modport store (input wr_en, sel, wdata, vid_a, vid_b, output rdata, pid_a, pid_b, hit_a, hit_b);
	modport user (output wr_en, sel, wdata, vid_a, vid_b, input rdata, pid_a, pid_b, hit_a, hit_b);
endinterface : vpm_store_if

// File: vpm_map_store.sv
// Purpose: storage of the map registers and lookup of physical identifiers
// Assumes: writes arrive only after access checks passed
// Notes: contents have no reset; they stay unknown until software writes them
`timescale 1ns/1ps
module vpm_map_store
	import vpm_pkg::*;
#(
	parameter int REGS = VPM_REG_COUNT
) (
	input wire logic i_clk_sys,
	vpm_store_if.store bus
);
	logic [VPM_DATA_W-1:0] mem [REGS]; // [R6]

	// no reset on purpose: the fields are allowed to come up unknown
	always_ff @(posedge i_clk_sys) begin // [R13]
		if (bus.wr_en) begin
			mem[bus.sel] <= bus.wdata; // [R1]
		end
	end

	assign bus.rdata = mem[bus.sel];

	function automatic logic in_range(input logic [VPM_ID_W-1:0] vid);
		return (vid >= VPM_ID_W'(VPM_FIRST_VID)) &&
			(vid < VPM_ID_W'(VPM_FIRST_VID + REGS * VPM_ENTRIES_PER_REG));
	endfunction : in_range

	// entry k of a register sits at [16k+15:16k], lowest virtual id lowest
	function automatic logic [VPM_ID_W-1:0] entry_of(input logic [VPM_ID_W-1:0] vid);
		logic [VPM_ID_W-1:0] ofs;
		ofs = vid - VPM_ID_W'(VPM_FIRST_VID);
		return mem[ofs[2]][6'(ofs[1:0]) * 6'(VPM_ENTRY_W) +: VPM_ENTRY_W]; // [R4] [R5] [R20]
	endfunction : entry_of

	assign bus.hit_a = in_range(bus.vid_a);
	assign bus.hit_b = in_range(bus.vid_b);
	assign bus.pid_a = bus.hit_a ? entry_of(bus.vid_a) : bus.vid_a;
	assign bus.pid_b = bus.hit_b ? entry_of(bus.vid_b) : bus.vid_b;
endmodule : vpm_map_store

// File: vpm_top.sv
// Purpose: system-register access, access control and id translation for map registers 1 and 2
// Assumes: request fields and configuration bits come from core logic on i_clk_sys
// Notes: every request decoded as map register 1 or 2 answers one cycle later with a single-cycle response pulse
`timescale 1ns/1ps
module vpm_top
	import vpm_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [1:0] i_req_el,
	input wire logic [1:0] i_op0,
	input wire logic [2:0] i_op1,
	input wire logic [3:0] i_crn,
	input wire logic [3:0] i_crm,
	input wire logic [2:0] i_op2,
	input wire logic [VPM_DATA_W-1:0] i_wdata,
	input wire logic i_hypervisor_control_present,
	input wire logic [2:0] i_highest_map_register_index,
	input wire logic i_non_secure,
	input wire logic i_secure_el2_enable,
	input wire logic i_el2_uses_64bit,
	input wire logic i_host_extension,
	input wire logic i_nested_virt,
	input wire logic i_nested_virt_memory,
	input wire logic i_trap_general_exceptions,
	input wire logic i_trap_lower_levels,
	input wire logic [VPM_BASE_W-1:0] i_base_address_field,
	input wire logic i_el1_map_enable,
	input wire logic i_el0_map_enable,
	input wire logic [VPM_VALID_W-1:0] i_map_entry_valid_bits,
	input wire logic [VPM_ID_W-1:0] i_el1_partition_identifier,
	input wire logic [VPM_ID_W-1:0] i_el0_partition_identifier,
	output logic o_resp_valid,
	output logic [2:0] o_resp_kind,
	output logic [VPM_DATA_W-1:0] o_rdata,
	output logic [VPM_DATA_W-1:0] o_mem_addr,
	output logic [VPM_ID_W-1:0] o_el1_phys_id,
	output logic [VPM_ID_W-1:0] o_el0_phys_id,
	output logic o_el1_mapped,
	output logic o_el0_mapped
);
	vpm_store_if sbus ();

	wire common_enc;
	wire hit_map1;
	wire hit_map2;
	wire req_hit;
	wire present;
	wire el2_on;
	wire nv_redirect;
	wire nv_only;
	vpm_resp_t el1_kind;
	vpm_resp_t el2_kind;
	vpm_resp_t el_kind;
	vpm_resp_t next_kind;
	wire acc_ok;
	wire [VPM_DATA_W-1:0] next_mem_addr;
	wire [VPM_DATA_W-1:0] next_rdata;
	wire next_el1_mapped;
	wire next_el0_mapped;

	assign common_enc = (i_op0 == VPM_OP0) && (i_op1 == VPM_OP1) &&
		(i_crn == VPM_CRN) && (i_crm == VPM_CRM); // [R2]
	assign hit_map1 = common_enc && (i_op2 == VPM_OP2_MAP1); // [R3]
	assign hit_map2 = common_enc && (i_op2 == VPM_OP2_MAP2); // [R3]
	assign req_hit = hit_map1 || hit_map2;

	// the index field also bounds how many map registers exist at all
	assign present = i_hypervisor_control_present &&
		(hit_map2 ? (i_highest_map_register_index > VPM_MIN_INDEX_MAP2) // [R9] [R7]
			: (i_highest_map_register_index > VPM_MIN_INDEX_MAP1)); // [R21] [R8]

	assign el2_on = i_non_secure || i_secure_el2_enable;
	assign nv_redirect = i_nested_virt && i_nested_virt_memory;
	assign nv_only = i_nested_virt && !i_nested_virt_memory;

	// priority follows the trap order: el3 trap, not applicable, redirect, el2 trap
	assign el1_kind = (i_trap_lower_levels && nv_only) ? VPM_RESP_TRAP_EL3 : // [R18]
		(el2_on && i_trap_general_exceptions) ? VPM_RESP_UNDEF : // [R16]
		nv_redirect ? VPM_RESP_MEM : // [R15]
		(!i_trap_lower_levels && el2_on && i_el2_uses_64bit && i_host_extension && nv_only)
			? VPM_RESP_TRAP_EL2 : VPM_RESP_UNDEF; // [R19]
	assign el2_kind = i_trap_lower_levels ? VPM_RESP_TRAP_EL3 : // [R17]
		el2_on ? VPM_RESP_OK : VPM_RESP_UNDEF; // [R14]
	assign el_kind = (i_req_el == VPM_EL3) ? VPM_RESP_OK : // [R14]
		(i_req_el == VPM_EL2) ? el2_kind :
		(i_req_el == VPM_EL1) ? el1_kind : VPM_RESP_UNDEF; // [R14]
	assign next_kind = present ? el_kind : VPM_RESP_UNDEF; // [R9] [R21]
	assign acc_ok = i_req_valid && req_hit && (next_kind == VPM_RESP_OK);

	assign sbus.wr_en = acc_ok && i_req_write; // [R1]
	assign sbus.sel = hit_map2 ? 1'b1 : 1'b0; // [R3]
	assign sbus.wdata = i_wdata;
	assign next_rdata = (acc_ok && !i_req_write) ? sbus.rdata : VPM_RDATA_RESET; // [R1]

	// the core performs the redirected load or store itself at this address
	assign next_mem_addr = (VPM_DATA_W'(i_base_address_field) << VPM_BASE_SHIFT) +
		VPM_DATA_W'(hit_map2 ? VPM_MEM_OFS_MAP2 : VPM_MEM_OFS_MAP1); // [R15]

	assign sbus.vid_a = i_el1_partition_identifier;
	assign sbus.vid_b = i_el0_partition_identifier;
	// ids outside 4..11 pass through; other map registers handle them
	assign next_el1_mapped = el2_on && i_el1_map_enable && sbus.hit_a && // [R10] [R12]
		i_map_entry_valid_bits[i_el1_partition_identifier[4:0]]; // [R11]
	assign next_el0_mapped = el2_on && i_el0_map_enable && sbus.hit_b && // [R10] [R12]
		i_map_entry_valid_bits[i_el0_partition_identifier[4:0]]; // [R11]

	vpm_map_store #(
		.REGS(VPM_REG_COUNT)
	) u_store (
		.i_clk_sys(i_clk_sys),
		.bus(sbus.store)
	);

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_resp_valid <= 1'b0;
			o_resp_kind <= VPM_RESP_OK;
			o_rdata <= VPM_RDATA_RESET;
			o_mem_addr <= VPM_RDATA_RESET;
		end else begin
			o_resp_valid <= i_req_valid && req_hit; // [R1]
			o_resp_kind <= (i_req_valid && req_hit) ? next_kind : VPM_RESP_OK;
			o_rdata <= next_rdata;
			o_mem_addr <= (i_req_valid && req_hit && next_kind == VPM_RESP_MEM)
				? next_mem_addr : VPM_RDATA_RESET;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_el1_phys_id <= VPM_ID_RESET;
			o_el0_phys_id <= VPM_ID_RESET;
			o_el1_mapped <= 1'b0;
			o_el0_mapped <= 1'b0;
		end else begin
			o_el1_phys_id <= next_el1_mapped ? sbus.pid_a : i_el1_partition_identifier; // [R22]
			o_el0_phys_id <= next_el0_mapped ? sbus.pid_b : i_el0_partition_identifier; // [R22]
			o_el1_mapped <= next_el1_mapped;
			o_el0_mapped <= next_el0_mapped;
		end
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);

	resp_pulse_a: assert property ( // [R1]
		i_req_valid && req_hit |=> o_resp_valid ##1 !o_resp_valid || $past(i_req_valid && req_hit))
		else $error("decoded request gave no single-cycle response");

	enc_decode_a: assert property ( // [R2]
		i_req_valid && !common_enc |=> !o_resp_valid)
		else $error("foreign encoding was answered");

	sel_roundtrip_a: assert property ( // [R3]
		(i_req_valid && hit_map2 && i_req_write && acc_ok) ##2
		(i_req_valid && hit_map2 && !i_req_write && acc_ok)
		|=> o_rdata == $past(i_wdata, 3))
		else $error("map register 2 read did not return the written word");

	entry_pos_a: assert property ( // [R5]
		next_el1_mapped && i_el1_partition_identifier == 16'h0009
		|=> o_el1_phys_id == $past(u_store.mem[1][31:16]))
		else $error("virtual id 9 not taken from bits 31 to 16");

	absent_undef_a: assert property ( // [R9]
		i_req_valid && hit_map2 && i_highest_map_register_index <= VPM_MIN_INDEX_MAP2
		|=> o_resp_valid && o_resp_kind == VPM_RESP_UNDEF)
		else $error("absent map register 2 not undefined");

	el_rights_a: assert property ( // [R14]
		i_req_valid && req_hit && present && i_req_el == VPM_EL3
		|=> o_resp_kind == VPM_RESP_OK)
		else $error("el3 access was not granted");

	el0_deny_a: assert property ( // [R14]
		i_req_valid && req_hit && i_req_el == VPM_EL0 |=> o_resp_kind == VPM_RESP_UNDEF)
		else $error("el0 access was not denied");

	redirect_addr_a: assert property ( // [R15]
		i_req_valid && hit_map2 && present && i_req_el == VPM_EL1 && nv_redirect &&
		!(el2_on && i_trap_general_exceptions)
		|=> o_resp_kind == VPM_RESP_MEM &&
		o_mem_addr == (VPM_DATA_W'($past(i_base_address_field)) << 12) + 64'h0000_0000_0000_0950)
		else $error("wrong redirect address for map register 2");

	tge_na_a: assert property ( // [R16]
		i_req_valid && req_hit && present && i_req_el == VPM_EL1 && el2_on &&
		i_trap_general_exceptions && !(i_trap_lower_levels && nv_only)
		|=> o_resp_kind == VPM_RESP_UNDEF)
		else $error("el1 access not treated as not applicable");

	trap_el3_a: assert property ( // [R17]
		i_req_valid && req_hit && present && i_req_el == VPM_EL2 && i_trap_lower_levels
		|=> o_resp_kind == VPM_RESP_TRAP_EL3 && o_mem_addr == VPM_RDATA_RESET)
		else $error("el2 access not trapped to el3");

	trap_el2_a: assert property ( // [R19]
		i_req_valid && req_hit && present && i_req_el == VPM_EL1 && !i_trap_lower_levels &&
		el2_on && i_el2_uses_64bit && i_host_extension && nv_only && !i_trap_general_exceptions
		|=> o_resp_kind == VPM_RESP_TRAP_EL2 && o_rdata == VPM_RDATA_RESET)
		else $error("el1 access not trapped to el2");

	ignore_off_a: assert property ( // [R12]
		!el2_on |=> !o_el1_mapped && !o_el0_mapped)
		else $error("translation applied with el2 disabled");

	valid_bit_a: assert property ( // [R11]
		!i_map_entry_valid_bits[i_el0_partition_identifier[4:0]]
		|=> !o_el0_mapped && o_el0_phys_id == $past(i_el0_partition_identifier))
		else $error("invalid entry was used for translation");

	write_ok_c: cover property (i_req_valid && sbus.wr_en ##1 o_resp_kind == VPM_RESP_OK);
	redirect_c: cover property (i_req_valid && req_hit ##1 o_resp_kind == VPM_RESP_MEM);
	trap_el2_c: cover property (i_req_valid && req_hit ##1 o_resp_kind == VPM_RESP_TRAP_EL2);
	mapped_c: cover property (next_el1_mapped ##1 o_el1_mapped);
endmodule : vpm_top

// File: vpm_core_model.sv
// Purpose: core model issuing map-register instructions and capturing the answer
// Assumes: drives on the falling edge; the answer stands from the taking edge until the next rising edge
// Notes: between instructions the operand bus shows inverted data, never stale data
`timescale 1ns/1ps
module vpm_core_model
	import vpm_pkg::*;
(
	input wire logic i_clk_sys,
	output logic o_req_valid,
	output logic o_req_write,
	output logic [1:0] o_req_el,
	output logic [12:0] o_enc,
	output logic [2:0] o_op2,
	output logic [VPM_DATA_W-1:0] o_wdata,
	input wire logic i_resp_valid,
	input wire logic [2:0] i_resp_kind,
	input wire logic [VPM_DATA_W-1:0] i_rdata,
	input wire logic [VPM_DATA_W-1:0] i_mem_addr
);
	logic got_valid;
	logic [2:0] got_kind;
	logic [VPM_DATA_W-1:0] got_rdata;
	logic [VPM_DATA_W-1:0] got_addr;
	initial begin
		o_req_valid = 1'b0;
		o_req_write = 1'b0;
		o_req_el = 2'h0;
		o_enc = 13'h0000;
		o_op2 = 3'h0;
		o_wdata = 64'h0000_0000_0000_0000;
	end
	task automatic access(input logic wr, input logic [1:0] el, input logic [2:0] op2,
		input logic [VPM_DATA_W-1:0] d, input logic [12:0] enc);
		@(negedge i_clk_sys);
		o_req_valid = 1'b1;
		o_req_write = wr;
		o_req_el = el;
		o_op2 = op2;
		o_enc = enc;
		o_wdata = d;
		@(negedge i_clk_sys);
		// the answer stands only until the next rising edge, so take it here
		got_valid = i_resp_valid;
		got_kind = i_resp_kind;
		got_rdata = i_rdata;
		got_addr = i_mem_addr;
		o_req_valid = 1'b0;
		o_wdata = ~d;
	endtask : access
endmodule : vpm_core_model

// File: vpm_top_tb.sv
// Purpose: self-checking bench for the map-register block
// Assumes: config bits change only between instructions
// Notes: map contents have no reset, so every read follows a write
`timescale 1ns/1ps
module vpm_top_tb;
	import vpm_pkg::*;
	localparam logic [12:0] ENC = {VPM_OP0, VPM_OP1, VPM_CRN, VPM_CRM};
	localparam logic [63:0] D1 = 64'h7777_6666_5555_4444;
	localparam logic [63:0] D2 = 64'hbbbb_aaaa_9999_8888;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	// hyp, ns, secure_el2_enable, el2_64, e2h, nv, nv_mem, tge, trap_lower
	logic [8:0] cf = 9'h1d0;
	logic [2:0] hi_idx = 3'h2;
	logic [VPM_BASE_W-1:0] base = 52'h0_0012_3456_789a;
	logic [1:0] men = 2'h0;
	logic [VPM_VALID_W-1:0] vbits = 32'h0000_0000;
	logic [VPM_ID_W-1:0] vid1 = 16'h0000;
	logic [VPM_ID_W-1:0] vid0 = 16'h0000;
	logic rv, wr, resp_v, map1, map0;
	logic [1:0] el;
	logic [12:0] enc;
	logic [2:0] op2, kind;
	logic [63:0] wd, rdata, maddr;
	logic [15:0] pid1, pid0, e;
	logic [13:0] tbl [10];
	int err_total = 0;
	int comparisons = 0;
	initial forever #20 clk_sys = ~clk_sys;
	vpm_core_model vpm_core_model_i (.i_clk_sys(clk_sys), .o_req_valid(rv), .o_req_write(wr),
		.o_req_el(el), .o_enc(enc), .o_op2(op2), .o_wdata(wd), .i_resp_valid(resp_v),
		.i_resp_kind(kind), .i_rdata(rdata), .i_mem_addr(maddr));
	vpm_top vpm_top_i (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_req_valid(rv),
		.i_req_write(wr), .i_req_el(el), .i_op0(enc[12:11]), .i_op1(enc[10:8]),
		.i_crn(enc[7:4]), .i_crm(enc[3:0]), .i_op2(op2), .i_wdata(wd),
		.i_hypervisor_control_present(cf[8]), .i_highest_map_register_index(hi_idx),
		.i_non_secure(cf[7]), .i_secure_el2_enable(cf[6]), .i_el2_uses_64bit(cf[5]),
		.i_host_extension(cf[4]), .i_nested_virt(cf[3]), .i_nested_virt_memory(cf[2]),
		.i_trap_general_exceptions(cf[1]), .i_trap_lower_levels(cf[0]),
		.i_base_address_field(base), .i_el1_map_enable(men[1]), .i_el0_map_enable(men[0]),
		.i_map_entry_valid_bits(vbits), .i_el1_partition_identifier(vid1),
		.i_el0_partition_identifier(vid0), .o_resp_valid(resp_v), .o_resp_kind(kind),
		.o_rdata(rdata), .o_mem_addr(maddr), .o_el1_phys_id(pid1), .o_el0_phys_id(pid0),
		.o_el1_mapped(map1), .o_el0_mapped(map0));
	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rq(input logic w, input logic [1:0] l, input logic [2:0] o,
		input logic [63:0] d, input logic [2:0] k);
		vpm_core_model_i.access(w, l, o, d, ENC);
		chk(vpm_core_model_i.got_valid, 1'b1);
		chk(vpm_core_model_i.got_kind, k);
	endtask : rq
	task automatic xl(input logic [15:0] v, input logic [15:0] p, input logic m);
		vid1 = v;
		vid0 = v;
		@(negedge clk_sys);
		chk({pid1, pid0, map1, map0}, {p, p, m, m});
	endtask : xl
	task automatic s_rw;
		rq(1'b1, VPM_EL3, VPM_OP2_MAP1, D1, VPM_RESP_OK);
		rq(1'b1, VPM_EL2, VPM_OP2_MAP2, D2, VPM_RESP_OK);
		rq(1'b0, VPM_EL2, VPM_OP2_MAP2, 64'h0, VPM_RESP_OK);
		chk(vpm_core_model_i.got_rdata, D2);
		rq(1'b0, VPM_EL3, VPM_OP2_MAP1, 64'h0, VPM_RESP_OK);
		chk(vpm_core_model_i.got_rdata, D1);
		rq(1'b1, VPM_EL0, VPM_OP2_MAP1, 64'h0, VPM_RESP_UNDEF);
		rq(1'b0, VPM_EL3, VPM_OP2_MAP1, 64'h0, VPM_RESP_OK);
		chk(vpm_core_model_i.got_rdata, D1);
	endtask : s_rw
	task automatic s_decode;
		// first four corrupt one field each; the rest walk op2 through all eight codes
		for (int i = 0; i < 12; i++) begin
			vpm_core_model_i.access(1'b0, VPM_EL3, 3'(i), 64'h0, (i < 4) ? ENC ^ (13'h1 << (i * 4)) : ENC);
			chk(vpm_core_model_i.got_valid,
				(i >= 4) && (3'(i) == VPM_OP2_MAP1 || 3'(i) == VPM_OP2_MAP2));
		end
	endtask : s_decode
	task automatic s_present;
		cf = 9'h0d0;
		rq(1'b0, VPM_EL3, VPM_OP2_MAP1, 64'h0, VPM_RESP_UNDEF);
		cf = 9'h1d0;
		hi_idx = 3'h0;
		rq(1'b0, VPM_EL3, VPM_OP2_MAP1, 64'h0, VPM_RESP_UNDEF);
		hi_idx = 3'h1;
		rq(1'b0, VPM_EL3, VPM_OP2_MAP1, 64'h0, VPM_RESP_OK);
		rq(1'b0, VPM_EL3, VPM_OP2_MAP2, 64'h0, VPM_RESP_UNDEF);
		hi_idx = 3'h7;
		rq(1'b0, VPM_EL3, VPM_OP2_MAP2, 64'h0, VPM_RESP_OK);
		hi_idx = 3'h2;
	endtask : s_present
	task automatic s_rights;
		tbl = '{{9'h1d0, VPM_EL0, VPM_RESP_UNDEF}, {9'h110, VPM_EL2, VPM_RESP_UNDEF},
			{9'h170, VPM_EL2, VPM_RESP_OK}, {9'h100, VPM_EL3, VPM_RESP_OK},
			{9'h1d1, VPM_EL2, VPM_RESP_TRAP_EL3}, {9'h1d9, VPM_EL1, VPM_RESP_TRAP_EL3},
			{9'h1d2, VPM_EL1, VPM_RESP_UNDEF}, {9'h1d8, VPM_EL1, VPM_RESP_UNDEF},
			{9'h1f8, VPM_EL1, VPM_RESP_TRAP_EL2}, {9'h1d8, VPM_EL0, VPM_RESP_UNDEF}};
		for (int i = 0; i < 10; i++) begin
			cf = tbl[i][13:5];
			rq(1'b0, tbl[i][4:3], VPM_OP2_MAP2, 64'h0, tbl[i][2:0]);
		end
		cf = 9'h10c;
		rq(1'b0, VPM_EL1, VPM_OP2_MAP1, 64'h0, VPM_RESP_MEM);
		chk(vpm_core_model_i.got_addr, {base, 12'h000} + 64'(VPM_MEM_OFS_MAP1));
		cf = 9'h1ec;
		rq(1'b1, VPM_EL1, VPM_OP2_MAP2, 64'h0, VPM_RESP_MEM);
		chk(vpm_core_model_i.got_addr, {base, 12'h000} + 64'(VPM_MEM_OFS_MAP2));
		cf = 9'h1d0;
	endtask : s_rights
	task automatic s_xlate;
		men = 2'h3;
		vbits = 32'hffff_ffff;
		for (int v = 4; v < 12; v++) begin
			e = 16'(((v < 8) ? D1 : D2) >> (16 * (v % 4)));
			xl(16'(v), e, 1'b1);
		end
		xl(16'h000c, 16'h000c, 1'b0);
		vbits = 32'hffff_fdff;
		xl(16'h0009, 16'h0009, 1'b0);
		vbits = 32'hffff_ffff;
		men = 2'h0;
		xl(16'h0009, 16'h0009, 1'b0);
		// each enable must act on its own level only
		men = 2'h2;
		@(negedge clk_sys);
		chk({map1, map0}, 2'h2);
		men = 2'h1;
		@(negedge clk_sys);
		chk({pid1, map1, map0}, {16'h0009, 2'h1});
		men = 2'h3;
		cf = 9'h120;
		xl(16'h0009, 16'h0009, 1'b0);
		cf = 9'h1d0;
	endtask : s_xlate
	initial begin
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		@(negedge clk_sys);
		chk({resp_v, kind, map1, map0, pid1, pid0}, 64'h0);
		chk(rdata | maddr, 64'h0);
		s_rw();
		s_decode();
		s_present();
		s_rights();
		s_xlate();
		print_verdict();
	end
	// watchdog: a hung task still reaches the verdict
	initial begin
		#400000;
		err_total++;
		print_verdict();
	end
endmodule : vpm_top_tb
